// ===== tb/oms_host.sv
`timescale 1ns/1ps
// Host of the two-wire port: clocks frames out and samples read data
module oms_host (
    input  wire i_sys_clk, // System clock, paces SCK
    input  wire i_line,    // Resolved SDIO level
    output reg  o_sck,     // Serial clock to device
    output reg  o_sdio     // Host drive onto SDIO
);
    // SCK idles high; a stray edge here would shift every later frame by a bit
    initial begin
        o_sck = 1'b1;
        o_sdio = 1'b1;
    end

    // One 16-bit frame, MSB first, 70 ns low and 90 ns high phases; read bits sampled before each fall
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        integer i;
        begin
            q = 8'h00;
            for (i = 0; i < 16; i = i + 1) begin
                @(posedge i_sys_clk);
                o_sck <= 1'b0;
                if (i < 8 || a[7])
                    o_sdio <= (i < 8) ? a[7 - i] : d[15 - i];
                else if (i == 8)
                    o_sdio <= ~o_sdio; // Inverted, still driven: a stale level must not pass as data
                repeat (7) @(posedge i_sys_clk);
                o_sck <= 1'b1;
                repeat (8) @(posedge i_sys_clk);
                if (i >= 8)
                    q[15 - i] = i_line;
            end
            // Writes need 100 us to land before the next frame, reads 250 ns
            repeat (a[7] ? 10000 : 25) @(posedge i_sys_clk);
        end
    endtask
endmodule // oms_host

// ===== tb/oms_regs_chk.sv
`timescale 1ns/1ps
// Port-level checks of the serial register block
module oms_regs_chk (
    input wire i_sys_clk,      // System clock
    input wire i_rst,          // Async reset, active high
    input wire i_sck,          // Serial clock pin
    input wire o_sdio,         // Serial data out
    input wire o_sdio_oe,      // Serial data drive enable
    input wire o_analog_pd,    // Analog power-down level
    input wire o_part_reset,   // Soft reset pulse
    input wire o_dump_restart, // Dump restart pulse
    input wire o_dump_advance  // Dump advance pulse
);
    reg       sck_q;
    reg [7:0] since_rise;
    reg [7:0] since_fall;

    // Cycles since the pin last rose or fell; saturates so idle time never wraps
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sck_q      <= 1'b1;
            since_rise <= 8'hFF;
            since_fall <= 8'hFF;
        end else begin
            sck_q      <= i_sck;
            since_rise <= (i_sck && !sck_q) ? 8'h00 : since_rise + {7'h00, since_rise != 8'hFF};
            since_fall <= (!i_sck && sck_q) ? 8'h00 : since_fall + {7'h00, since_fall != 8'hFF};
        end
    end

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    // Outputs may only move shortly after a host edge, allowing for the synchroniser; the drive may also drop at once on power-down
    property p_reset_pulse; o_part_reset |-> since_rise < 8'h0C ##1 !o_part_reset; endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("soft reset pulse misplaced");
    property p_reset_quiet; o_part_reset |=> !o_sdio_oe; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("drive kept over soft reset");
    property p_pd_quiet; o_analog_pd |=> !o_sdio_oe; endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("drive while powered down");
    property p_oe_on_rise; $rose(o_sdio_oe) |-> since_rise < 8'h0C; endproperty
    a_oe_on_rise: assert property (p_oe_on_rise) else $error("drive began away from a rise");
    property p_oe_holds; $rose(o_sdio_oe) |-> o_sdio_oe [*8]; endproperty
    a_oe_holds: assert property (p_oe_holds) else $error("drive dropped inside a bit");
    property p_oe_off; $fell(o_sdio_oe) |-> since_fall < 8'h0C || o_analog_pd; endproperty
    a_oe_off: assert property (p_oe_off) else $error("drive released away from a fall");
    property p_data_on_rise; !$stable(o_sdio) |-> since_rise < 8'h0C; endproperty
    a_data_on_rise: assert property (p_data_on_rise) else $error("data moved off a rise");
    property p_restart; o_dump_restart |-> since_rise < 8'h0C ##1 !o_dump_restart; endproperty
    a_restart: assert property (p_restart) else $error("dump restart pulse misplaced");
    property p_advance; o_dump_advance |-> since_rise < 8'h0C ##1 !o_dump_advance; endproperty
    a_advance: assert property (p_advance) else $error("dump advance pulse misplaced");
endmodule // oms_regs_chk

bind oms_regs oms_regs_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sck(i_sck),
    .o_sdio(o_sdio), .o_sdio_oe(o_sdio_oe), .o_analog_pd(o_analog_pd),
    .o_part_reset(o_part_reset), .o_dump_restart(o_dump_restart),
    .o_dump_advance(o_dump_advance));

// ===== tb/oms_regs_tb.sv
`timescale 1ns/1ps
`include "oms_defines.vh"
module oms_regs_tb;
    reg         i_sys_clk, i_rst, i_motion_valid, i_frame_valid;
    reg  [7:0]  i_motion_dy, i_motion_dx, i_pixel_sum, i_pixel_data, rd_q;
    reg  [8:0]  i_feature_count;
    reg  [5:0]  i_max_pixel, i_min_pixel;
    reg  [15:0] i_exposure;
    wire        i_sck, host_sdio, o_sdio, o_sdio_oe, o_analog_pd, o_awake;
    wire        o_part_reset, o_dump_restart, o_dump_advance;
    integer     num_errors, total_checks;
    // Device wins the wire while driving; overlap after a read is brief
    wire        i_sdio = o_sdio_oe ? o_sdio : host_sdio;

    oms_regs dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sck(i_sck), .i_sdio(i_sdio),
        .o_sdio(o_sdio), .o_sdio_oe(o_sdio_oe), .i_motion_valid(i_motion_valid),
        .i_motion_dy(i_motion_dy), .i_motion_dx(i_motion_dx), .i_frame_valid(i_frame_valid),
        .i_feature_count(i_feature_count), .i_max_pixel(i_max_pixel),
        .i_min_pixel(i_min_pixel), .i_pixel_sum(i_pixel_sum), .i_pixel_data(i_pixel_data),
        .i_exposure(i_exposure), .o_analog_pd(o_analog_pd), .o_awake(o_awake),
        .o_part_reset(o_part_reset), .o_dump_restart(o_dump_restart),
        .o_dump_advance(o_dump_advance));
    oms_host host (.i_sys_clk(i_sys_clk), .i_line(i_sdio), .o_sck(i_sck), .o_sdio(host_sdio));

    // 100 MHz system clock
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("BAD %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
        begin
            host.xfer({1'b0, a}, 8'h00, rd_q);
            check(what, exp, rd_q);
        end
    endtask
    task wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({1'b1, a}, d, rd_q);
    endtask
    task step(input logic [7:0] y, input logic [7:0] x, input integer n);
        begin
            @(posedge i_sys_clk);
            i_motion_valid <= 1'b1;
            i_motion_dy <= y;
            i_motion_dx <= x;
            repeat (n) @(posedge i_sys_clk);
            i_motion_valid <= 1'b0;
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, num_errors);
            if (num_errors == 0 && total_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    task t_reset;
        begin
            rd_chk("config", 7'h00, 8'h00);
            rd_chk("status", 7'h01, {`OMS_PART_CODE, 5'h01});
            rd_chk("inverse id", 7'h11, ~{`OMS_PART_CODE, 5'h00});
            rd_chk("vmotion", 7'h02, 8'h00);
            $display("reset test done");
        end
    endtask
    task t_motion;
        begin
            step(8'h03, 8'hFB, 2);
            rd_chk("vmotion", 7'h02, 8'h06);
            rd_chk("vmotion cleared", 7'h02, 8'h00);
            rd_chk("hmotion", 7'h03, 8'hF6);
            rd_chk("hmotion cleared", 7'h03, 8'h00);
            $display("motion test done");
        end
    endtask
    task t_frame;
        begin
            @(posedge i_sys_clk);
            i_frame_valid <= 1'b1;
            i_feature_count <= 9'h1A3;
            i_max_pixel <= 6'h3F;
            i_min_pixel <= 6'h01;
            i_pixel_sum <= 8'h9F;
            i_exposure <= 16'h1234;
            i_pixel_data <= 8'hA5;
            @(posedge i_sys_clk);
            i_frame_valid <= 1'b0;
            rd_chk("surface_quality", 7'h04, 8'hD1);
            rd_chk("bright", 7'h05, 8'h3F);
            rd_chk("dark", 7'h06, 8'h01);
            rd_chk("psum", 7'h07, 8'h9F);
            rd_chk("exposure hi", 7'h09, 8'h12);
            rd_chk("exposure lo", 7'h0A, 8'h34);
            rd_chk("dump", 7'h08, 8'hA5);
            rd_chk("unmapped 0B", 7'h0B, 8'h00);
            rd_chk("unmapped 7F", 7'h7F, 8'h00);
            $display("frame test done");
        end
    endtask
    task t_config;
        begin
            wr(7'h00, 8'h3F);
            rd_chk("config masked", 7'h00, 8'h01);
            check("awake", 8'h01, {7'h00, o_awake});
            wr(7'h0B, 8'hFF);
            rd_chk("config kept", 7'h00, 8'h01);
            wr(7'h08, 8'h00);
            step(8'h05, 8'h00, 1);
            wr(7'h00, 8'h81);
            rd_chk("config after soft reset", 7'h00, 8'h01);
            rd_chk("vmotion after soft reset", 7'h02, 8'h00);
            wr(7'h00, 8'h40);
            check("powerdown", 8'h01, {7'h00, o_analog_pd});
            check("sdio released", 8'h00, {7'h00, o_sdio_oe});
            // Power-down blocks the port, so only a hard reset brings it back
            @(posedge i_sys_clk);
            i_rst <= 1'b1;
            repeat (2) @(posedge i_sys_clk);
            i_rst <= 1'b0;
            repeat (6) @(posedge i_sys_clk);
            check("powerdown cleared", 8'h00, {7'h00, o_analog_pd});
            rd_chk("config after reset", 7'h00, 8'h00);
            $display("config test done");
        end
    endtask

    // Main sequence
    initial begin
        {num_errors, total_checks} = 0;
        {i_rst, i_motion_valid, i_frame_valid} = 3'b100;
        {i_motion_dy, i_motion_dx, i_pixel_sum, i_pixel_data} = 32'h0;
        {i_feature_count, i_max_pixel, i_min_pixel, i_exposure} = 37'h0;
        repeat (6) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (8) @(posedge i_sys_clk);
        t_reset;
        t_motion;
        t_frame;
        t_config;
        end_of_test;
    end
    // Hang guard
    initial begin
        repeat (90000) @(posedge i_sys_clk);
        num_errors = num_errors + 1;
        end_of_test;
    end
endmodule // oms_regs_tb

// ===== verilog/oms_defines.vh
`ifndef OMS_DEFINES_VH
`define OMS_DEFINES_VH
// Register addresses
`define OMS_ADDR_CONFIG      7'h00
`define OMS_ADDR_STATUS      7'h01
`define OMS_ADDR_VMOTION     7'h02
`define OMS_ADDR_HMOTION     7'h03
`define OMS_ADDR_SURFACE_QUALITY       7'h04
`define OMS_ADDR_BRIGHT      7'h05
`define OMS_ADDR_DARK        7'h06
`define OMS_ADDR_PSUM        7'h07
`define OMS_ADDR_DUMP        7'h08
`define OMS_ADDR_EXP_HI      7'h09
`define OMS_ADDR_EXP_LO      7'h0A
`define OMS_ADDR_INV_ID      7'h11
// Configuration field positions
`define OMS_CFG_SOFT_RESET   7
`define OMS_CFG_POWERDOWN    6
`define OMS_CFG_STAY_AWAKE   0
// Writable configuration bits (reserved ones masked off)
`define OMS_CFG_WMASK        8'h41
`define OMS_CFG_RESET        8'h00
// Part code; value is arbitrary
`define OMS_PART_CODE        3'h5
// Frame and sleep timing
`define OMS_FRAME_RATE       1500
`define OMS_SLEEP_MS         1000
`define OMS_SLEEP_FRAMES     (`OMS_FRAME_RATE * `OMS_SLEEP_MS / 1000)
`define OMS_CLK_HZ           100000000
`define OMS_FRAME_CYCLES     (`OMS_CLK_HZ / `OMS_FRAME_RATE)
// Serial transfer width
`define OMS_BITS_PER_XFER    16
`endif

// ===== verilog/oms_regs.v
`timescale 1ns/1ps
`include "oms_defines.vh"
module oms_regs (
    input  wire       i_sys_clk,        // System clock, 100 MHz
    input  wire       i_rst,            // Async reset, active high
    input  wire       i_sck,            // Serial clock from host
    input  wire       i_sdio,           // Serial data pin, input side
    output reg        o_sdio,           // Serial data pin, output side
    output reg        o_sdio_oe,        // Serial data drive enable, high drives
    input  wire       i_motion_valid,   // One-cycle motion sample strobe
    input  wire [7:0] i_motion_dy,      // Signed vertical step
    input  wire [7:0] i_motion_dx,      // Signed horizontal step
    input  wire       i_frame_valid,    // One-cycle frame statistics strobe
    input  wire [8:0] i_feature_count,  // Features seen in frame
    input  wire [5:0] i_max_pixel,      // Brightest pixel of frame
    input  wire [5:0] i_min_pixel,      // Darkest pixel of frame
    input  wire [7:0] i_pixel_sum,      // Frame brightness total
    input  wire [7:0] i_pixel_data,     // Next image dump byte
    input  wire [15:0] i_exposure,      // Exposure value
    output wire       o_analog_pd,      // Analog power-down level
    output reg        o_awake,          // Sensor awake level
    output reg        o_part_reset,     // One-cycle soft reset pulse
    output reg        o_dump_restart,   // One-cycle pulse on dump write
    output reg        o_dump_advance    // One-cycle pulse on dump read
);
    localparam ST_ADDR = 2'h0;
    localparam ST_WDAT = 2'h1;
    localparam ST_RDAT = 2'h2;

    reg  [1:0]  state;
    reg  [3:0]  bit_cnt;
    reg  [7:0]  shift;
    reg  [6:0]  addr;
    reg         sck_q;
    reg  [7:0]  sensor_config;
    reg  [7:0]  vertical_motion;
    reg  [7:0]  horizontal_motion;
    reg  [7:0]  surface_quality;
    reg  [5:0]  brightest_pixel;
    reg  [5:0]  darkest_pixel;
    reg  [7:0]  frame_brightness_total;
    reg  [15:0] exposure;
    reg  [7:0]  rd_data;
    reg  [7:0]  rd_shift;
    reg  [31:0] frame_cnt;
    reg  [15:0] idle_frames;
    reg         wr_stb;
    reg         rd_stb;
    wire        sck_s;
    wire        sdio_s;
    wire        sck_rise;
    wire        sck_fall;
    wire [7:0]  part_code_field;

    assign part_code_field = {`OMS_PART_CODE, 5'h00};

    // Serial clock and data cross into the system domain here.
    // The host parks SCK high between frames. The clock synchroniser
    // therefore resets to high as well: a low reset value would make the
    // first clocks after reset look like a rising edge, and that phantom
    // edge would shift one stray bit into the address and put every later
    // frame out of step with the host until the next reset.
    oms_sync3 #(
        .IDLE      (1'b1)
    ) u_sync_sck (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_async   (i_sck),
        .o_level   (sck_s)
    );
    oms_sync3 u_sync_sdio (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_async   (i_sdio),
        .o_level   (sdio_s)
    );

    assign sck_rise = sck_s & ~sck_q;
    assign sck_fall = ~sck_s & sck_q;
    assign o_analog_pd = sensor_config[`OMS_CFG_POWERDOWN];

    // Read mux; unmapped addresses give zero.
    // The mux is combinational and is only sampled on the first data rise
    // of a read, so the whole byte comes from one instant. This keeps a
    // motion step that lands in the middle of a read from tearing the byte
    // that goes out on the wire.
    // Reserved configuration bits and the self-clearing reset bit are
    // masked here, so the host never reads back a one that it cannot
    // clear. Status bits 4 to 1 are reserved and read zero.
    // The inverse part code lets the host test the port for stuck lines.
    always @* begin
        case (addr)
            `OMS_ADDR_CONFIG:  rd_data = sensor_config & `OMS_CFG_WMASK;
            `OMS_ADDR_STATUS:  rd_data = part_code_field | {7'h00, o_awake};
            `OMS_ADDR_VMOTION: rd_data = vertical_motion;
            `OMS_ADDR_HMOTION: rd_data = horizontal_motion;
            `OMS_ADDR_SURFACE_QUALITY:   rd_data = surface_quality;
            `OMS_ADDR_BRIGHT:  rd_data = {2'h0, brightest_pixel};
            `OMS_ADDR_DARK:    rd_data = {2'h0, darkest_pixel};
            `OMS_ADDR_PSUM:    rd_data = frame_brightness_total;
            `OMS_ADDR_DUMP:    rd_data = i_pixel_data;
            `OMS_ADDR_EXP_HI:  rd_data = exposure[15:8];
            `OMS_ADDR_EXP_LO:  rd_data = exposure[7:0];
            `OMS_ADDR_INV_ID:  rd_data = ~part_code_field;
            default:           rd_data = 8'h00;
        endcase
    end

    // Frame layout as seen on the wire, one bit per SCK rise, MSB first:
    //   rise 1      direction, 1 for a write and 0 for a read
    //   rises 2-8   register address
    //   rises 9-16  data, from the host on a write, from us on a read
    // The host changes SDIO while SCK is low and we sample on the rise.
    // On a read we start driving only after the first data rise, so the
    // host has the whole low phase after the address to let go of the
    // line. We keep driving the last data bit until the next falling SCK,
    // which is the start of the following frame; the host must not drive
    // SDIO before that edge or the two sides fight over the wire.
    // Both pins come through the three-stage synchronisers, so an edge is
    // seen roughly four system clocks after it happens on the pin. This
    // bounds how fast the host may toggle SCK: edges closer than about
    // two system clocks apart can be merged or lost.
    // There is no transaction timer. If a noise edge puts the engine out
    // of step, the host recovers by a soft reset or by the hard reset;
    // power-down also resyncs it but then needs the hard reset to clear.
    // Trade-off: power-down holds the engine idle, which releases SDIO at
    // once but also means the host cannot clear power-down over the wire.
    //
    // Serial engine: 1 direction bit, 7 address bits, 8 data bits
    // Sampling on rising SCK; read data is also shifted out on rising SCK
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sck_q     <= 1'b1;
            state     <= ST_ADDR;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            addr      <= 7'h00;
            rd_shift  <= 8'h00;
            o_sdio    <= 1'b0;
            o_sdio_oe <= 1'b0;
            wr_stb    <= 1'b0;
            rd_stb    <= 1'b0;
        end else begin
            sck_q  <= sck_s;
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
            if (o_part_reset || sensor_config[`OMS_CFG_POWERDOWN]) begin
                // Power-down releases the pin and resyncs the port
                state     <= ST_ADDR;
                bit_cnt   <= 4'h0;
                o_sdio_oe <= 1'b0;
            end else begin
                case (state)
                    ST_ADDR: begin
                        if (sck_fall) begin
                            o_sdio_oe <= 1'b0;
                        end
                        if (sck_rise) begin
                            shift   <= {shift[6:0], sdio_s};
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == 4'h7) begin
                                addr    <= {shift[5:0], sdio_s};
                                bit_cnt <= 4'h0;
                                state   <= shift[6] ? ST_WDAT : ST_RDAT;
                            end
                        end
                    end
                    ST_WDAT: begin
                        if (sck_rise) begin
                            shift   <= {shift[6:0], sdio_s};
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == 4'h7) begin
                                bit_cnt <= 4'h0;
                                wr_stb  <= 1'b1;
                                state   <= ST_ADDR;
                            end
                        end
                    end
                    ST_RDAT: begin
                        // Device drives after the next rising edge
                        if (sck_rise) begin
                            if (bit_cnt == 4'h0) begin
                                o_sdio   <= rd_data[7];
                                rd_shift <= {rd_data[6:0], 1'b0};
                                rd_stb   <= 1'b1;
                            end else begin
                                o_sdio   <= rd_shift[7];
                                rd_shift <= {rd_shift[6:0], 1'b0};
                            end
                            o_sdio_oe <= 1'b1;
                            bit_cnt   <= bit_cnt + 4'h1;
                            if (bit_cnt == 4'h7) begin
                                bit_cnt <= 4'h0;
                                state   <= ST_ADDR;
                            end
                        end
                    end
                    default: begin
                        state <= ST_ADDR;
                    end
                endcase
            end
        end
    end

    // Configuration register and side-effect pulses.
    // A write with the reset bit set also keeps the other writable bits,
    // and the reset bit drops again on the clock after the pulse, so the
    // host never has to write it back to zero.
    // When the self-clear and a new write fall in one cycle the write is
    // applied last and wins, so no host write is ever lost.
    // Writes to read-only or unmapped addresses fall into the default
    // branch and leave the register as it was.
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sensor_config  <= `OMS_CFG_RESET;
            o_part_reset   <= 1'b0;
            o_dump_restart <= 1'b0;
            o_dump_advance <= 1'b0;
        end else begin
            o_part_reset   <= 1'b0;
            o_dump_restart <= 1'b0;
            o_dump_advance <= rd_stb && (addr == `OMS_ADDR_DUMP);
            if (o_part_reset) begin
                sensor_config[`OMS_CFG_SOFT_RESET] <= 1'b0;
            end
            if (wr_stb) begin
                case (addr)
                    `OMS_ADDR_CONFIG: begin
                        // Other bits written with reset are kept
                        sensor_config <= (shift & `OMS_CFG_WMASK)
                                       | {shift[`OMS_CFG_SOFT_RESET], 7'h00};
                        o_part_reset  <= shift[`OMS_CFG_SOFT_RESET];
                    end
                    `OMS_ADDR_DUMP: begin
                        o_dump_restart <= 1'b1;
                    end
                    default: begin
                        sensor_config <= sensor_config;
                    end
                endcase
            end
        end
    end

    // Motion accumulators; a new step in the read cycle survives the clear.
    // The accumulators wrap in eight bits: a host that polls too slowly
    // during fast motion sees a wrapped count, not a saturated one.
    // Limitation: the host must read often enough to avoid that wrap.
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            vertical_motion   <= 8'h00;
            horizontal_motion <= 8'h00;
        end else begin
            if (rd_stb && addr == `OMS_ADDR_VMOTION) begin
                vertical_motion <= i_motion_valid ? i_motion_dy : 8'h00;
            end else if (i_motion_valid) begin
                vertical_motion <= vertical_motion + i_motion_dy;
            end
            if (rd_stb && addr == `OMS_ADDR_HMOTION) begin
                horizontal_motion <= i_motion_valid ? i_motion_dx : 8'h00;
            end else if (i_motion_valid) begin
                horizontal_motion <= horizontal_motion + i_motion_dx;
            end
            if (o_part_reset) begin
                vertical_motion   <= 8'h00;
                horizontal_motion <= 8'h00;
            end
        end
    end

    // Frame statistics latched once per frame
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            surface_quality        <= 8'h00;
            brightest_pixel        <= 6'h00;
            darkest_pixel          <= 6'h00;
            frame_brightness_total <= 8'h00;
            exposure               <= 16'h0100;
        end else if (i_frame_valid) begin
            surface_quality        <= i_feature_count[8:1];
            brightest_pixel        <= i_max_pixel;
            darkest_pixel          <= i_min_pixel;
            frame_brightness_total <= i_pixel_sum;
            exposure               <= i_exposure;
        end
    end

    // Sleep timer: count frames with no motion, wake on motion.
    // The frame tick is a free-running divider of the system clock. The
    // stay-awake bit holds the idle count at zero; a soft reset clears it.
    // A step of zero in both axes does not count as motion, so a still
    // sensor still falls asleep after the full idle time.
    // Limitation: the idle time is long in system clocks, so only the
    // stay-awake path is cheap to exercise in simulation.
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            frame_cnt   <= 32'h0;
            idle_frames <= 16'h0;
            o_awake     <= 1'b1;
        end else begin
            if (frame_cnt >= `OMS_FRAME_CYCLES - 1) begin
                frame_cnt <= 32'h0;
            end else begin
                frame_cnt <= frame_cnt + 32'h1;
            end
            if (sensor_config[`OMS_CFG_STAY_AWAKE] || o_part_reset ||
                (i_motion_valid && (i_motion_dx != 8'h00 || i_motion_dy != 8'h00))) begin
                idle_frames <= 16'h0;
                o_awake     <= 1'b1;
            end else if (frame_cnt == 32'h0) begin
                if (idle_frames >= `OMS_SLEEP_FRAMES - 1) begin
                    o_awake <= 1'b0;
                end else begin
                    idle_frames <= idle_frames + 16'h1;
                end
            end
        end
    end
endmodule // oms_regs

// ===== verilog/oms_sync3.v
`timescale 1ns/1ps
// Three-stage synchroniser; output changes when stages two and three agree
// IDLE sets the reset level of every stage, so a pin that idles high
// does not show a false edge on the first clocks after reset
module oms_sync3 #(
    parameter [0:0] IDLE = 1'b0  // Reset level, matches the pin's idle level
) (
    input  wire i_sys_clk,   // System clock
    input  wire i_rst,       // Async reset, active high
    input  wire i_async,     // Asynchronous input
    output reg  o_level      // Filtered synchronous level
);
    reg s1;
    reg s2;
    reg s3;

    // Stage one feeds only stage two
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s1      <= IDLE;
            s2      <= IDLE;
            s3      <= IDLE;
            o_level <= IDLE;
        end else begin
            s1 <= i_async;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                o_level <= s3;
            end
        end
    end
endmodule // oms_sync3
